// ---- verilog/bld_dimmer.sv ----
// top level: button stepped led dimmer with sleep and wake control
`timescale 1ns/1ps
module bld_dimmer
  import bld_pkg::*;
#(
  parameter longint MAX_ON_CYC = BLD_MAX_ON_CYC,
  parameter int DEBOUNCE_CYC = BLD_DEBOUNCE_CYC
)
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic POWER_ON,
  input wire logic BUTTON_IN_PIN_N,
  input wire logic GP_IN1,
  input wire logic GP_IN2,
  output logic PULSE_OUT_PIN,
  output logic PULSE_OUT_OE,
  output logic ASLEEP,
  output logic [2:0] LEVEL
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bld_state_e state_q;
  bld_state_e state_d;
  bld_level_e level_q;
  bld_level_e level_d;
  logic [63:0] on_cnt_q;
  logic [63:0] on_cnt_d;
  logic [2:0] pins_q;
  logic [2:0] pins_now;
  logic pin_change;
  logic pressed;
  logic press_pulse;
  logic timeout;
  logic run_press;
  logic [7:0] high_time;
  logic pwm_enable;
  logic pwm_pulse;
  logic powered_q;

  // ----------------------------------------------------------------
  // button conditioning
  // ----------------------------------------------------------------
  bld_debounce #(.SETTLE_CYC(DEBOUNCE_CYC)) i_bld_debounce (
    .clk(CORE_CLK),
    .reset(RESET),
    .button_raw_n(BUTTON_IN_PIN_N),
    .pressed(pressed),
    .press_pulse(press_pulse)
  );

  // ----------------------------------------------------------------
  // wake detection on any input pin
  // ----------------------------------------------------------------
  assign pins_now = {GP_IN2, GP_IN1, BUTTON_IN_PIN_N};
  assign pin_change = pins_now != pins_q; // (R8)
  assign timeout = on_cnt_q >= 64'(MAX_ON_CYC - 1); // (R7)
  assign run_press = state_q == BLD_ST_RUN && press_pulse;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    level_d = level_q;
    on_cnt_d = on_cnt_q;
    case (state_q)
      BLD_ST_INIT:
      begin
        // cold start clears the level and the on-time counter, then sleeps
        level_d = BLD_OFF; // (R1) (R10)
        on_cnt_d = 64'h0;
        state_d = BLD_ST_SLEEP;
      end
      BLD_ST_SLEEP:
      begin
        level_d = BLD_OFF; // (R12)
        on_cnt_d = 64'h0;
        if (pin_change)
          state_d = BLD_ST_WAKE; // (R8) (R10)
      end
      BLD_ST_WAKE:
      begin
        // wait for the debounced press; other pin changes go back to sleep
        if (press_pulse)
        begin
          level_d = BLD_LOW; // (R2) (R11) (R12)
          state_d = BLD_ST_RUN;
        end
        else if (!pressed && pins_now[2:1] == pins_q[2:1] && BUTTON_IN_PIN_N)
          state_d = BLD_ST_SLEEP; // (R11)
      end
      BLD_ST_RUN:
      begin
        on_cnt_d = on_cnt_q + 64'h1; // (R7)
        if (timeout)
        begin
          level_d = BLD_OFF; // (R7)
          state_d = BLD_ST_SLEEP;
        end
        else if (run_press)
        begin
          if (level_q == BLD_FULL)
          begin
            level_d = BLD_OFF; // (R5)
            state_d = BLD_ST_SLEEP;
          end
          else
            level_d = bld_level_e'(level_q + 3'h1); // (R2) (R3)
        end
      end
      default:
        state_d = BLD_ST_INIT;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      state_q <= BLD_ST_INIT;
      level_q <= BLD_OFF;
      on_cnt_q <= 64'h0;
      pins_q <= 3'h7;
      powered_q <= 1'b0;
    end
    else
    begin
      // first POWER_ON after reset forces init; later POWER_ON highs leave the state alone
      powered_q <= powered_q | POWER_ON;
      if (POWER_ON && !powered_q)
        state_q <= BLD_ST_INIT; // (R10)
      else
        state_q <= state_d;
      level_q <= level_d;
      on_cnt_q <= on_cnt_d;
      pins_q <= pins_now;
    end
  end

  // ----------------------------------------------------------------
  // brightness selection
  // ----------------------------------------------------------------
  // off and any unused code select a zero high time, so the pin cannot pulse
  assign high_time = (level_q == BLD_LOW) ? BLD_LOW_ON : // (R6)
                     (level_q == BLD_MED) ? BLD_MED_ON :
                     (level_q == BLD_MEDHI) ? BLD_MEDHI_ON :
                     (level_q == BLD_HIGH) ? BLD_HIGH_ON :
                     (level_q == BLD_FULL) ? BLD_FULL_ON : 8'h00;

  assign pwm_enable = state_q == BLD_ST_RUN && level_q != BLD_OFF; // (R14)

  bld_pwm i_bld_pwm (
    .clk(CORE_CLK),
    .reset(RESET),
    .enable(pwm_enable),
    .high_time(high_time),
    .pulse(pwm_pulse)
  );

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      PULSE_OUT_PIN <= 1'b0;
      PULSE_OUT_OE <= 1'b0;
      ASLEEP <= 1'b1;
      LEVEL <= BLD_LEVEL_RESET;
    end
    else
    begin
      PULSE_OUT_PIN <= pwm_pulse; // (R4) (R14)
      PULSE_OUT_OE <= 1'b1; // (R9)
      ASLEEP <= state_q != BLD_ST_RUN;
      LEVEL <= level_q;
    end
  end

endmodule

// ---- verilog/bld_pkg.sv ----
// package: constants, states and timing figures for the stepped led dimmer
// Summary of operation
// (R1) power-up initialises, then sleeps until pressed
// (R2) first press lowest level, then step up
// (R3) five brightness levels plus one off
// (R4) wider pulse high time gives brighter output
// (R5) press at top level turns off, sleeps
// (R6) period and per-level high times are constants
// (R7) on-time counter returns to sleep at maximum
// (R8) asleep, any input pin change wakes
// (R9) pulse pin output, button and others inputs
// (R10) power-up initialises, wake goes to button path
// (R11) wake advances mode only if button pressed
// (R12) leaving sleep presets mode for lowest level
// (R13) button synchronised and debounced, one step each
// (R14) pulse output low when off or asleep
package bld_pkg;

  typedef enum logic [2:0] {
    BLD_OFF,
    BLD_LOW,
    BLD_MED,
    BLD_MEDHI,
    BLD_HIGH,
    BLD_FULL
  } bld_level_e;

  typedef enum logic [1:0] {
    BLD_ST_INIT,
    BLD_ST_SLEEP,
    BLD_ST_WAKE,
    BLD_ST_RUN
  } bld_state_e;

  localparam int BLD_CLK_HZ = 25000000;

  // pwm period and per-level high times, in clock ticks; each high time < period
  localparam logic [7:0] BLD_PERIOD = 8'h0e;
  localparam logic [7:0] BLD_LOW_ON = 8'h05;
  localparam logic [7:0] BLD_MED_ON = 8'h06;
  localparam logic [7:0] BLD_MEDHI_ON = 8'h08;
  localparam logic [7:0] BLD_HIGH_ON = 8'h0b;
  localparam logic [7:0] BLD_FULL_ON = 8'h0d;

  // maximum on time in microseconds before the controller sleeps again
  localparam longint BLD_MAX_ON_US = 64'd600000000;
  localparam longint BLD_MAX_ON_CYC = BLD_MAX_ON_US * BLD_CLK_HZ / 1000000;

  // debounce settling time in microseconds
  localparam int BLD_DEBOUNCE_US = 10000;
  localparam int BLD_DEBOUNCE_CYC = BLD_DEBOUNCE_US * (BLD_CLK_HZ / 1000000);

  localparam logic [2:0] BLD_LEVEL_RESET = 3'h0;
  localparam logic [7:0] BLD_PWM_CNT_RESET = 8'h00;

endpackage

// ---- verilog/bld_debounce.sv ----
// button synchroniser and debouncer giving one pulse per press
`timescale 1ns/1ps
module bld_debounce
  import bld_pkg::*;
#(
  parameter int SETTLE_CYC = BLD_DEBOUNCE_CYC
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic button_raw_n,
  output logic pressed,
  output logic press_pulse
);

  logic sync0_q;
  logic sync1_q;
  logic stable_q;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic diff;
  logic settled;

  // button is active low: a press pulls the pin down
  assign diff = sync1_q != stable_q;
  assign settled = cnt_q >= 32'(SETTLE_CYC - 1);
  assign cnt_d = diff ? (settled ? 32'h0 : cnt_q + 32'h1) : 32'h0;
  assign pressed = ~stable_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync0_q <= 1'b1;
      sync1_q <= 1'b1;
      stable_q <= 1'b1;
      cnt_q <= 32'h0;
      press_pulse <= 1'b0;
    end
    else
    begin
      sync0_q <= button_raw_n; // (R13)
      sync1_q <= sync0_q;
      cnt_q <= cnt_d;
      press_pulse <= diff && settled && stable_q; // (R13)
      if (diff && settled)
        stable_q <= sync1_q;
    end
  end

endmodule

// ---- verilog/bld_pwm.sv ----
// fixed-period pulse generator with selectable high time
`timescale 1ns/1ps
module bld_pwm
  import bld_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [7:0] high_time,
  output logic pulse
);

  logic [7:0] cnt_q;
  logic wrap;

  assign wrap = cnt_q >= BLD_PERIOD - 8'h01;

  always_ff @(posedge clk)
  begin
    if (reset || !enable)
      cnt_q <= BLD_PWM_CNT_RESET;
    else
      cnt_q <= wrap ? BLD_PWM_CNT_RESET : cnt_q + 8'h01; // (R6)
  end

  // wider high time keeps the pin high longer per period
  assign pulse = enable && (cnt_q < high_time); // (R4)

endmodule

// ---- testbench/bld_dimmer_chk.sv ----
// checker: port assertions for the stepped led dimmer
`timescale 1ns/1ps
module bld_dimmer_chk
  import bld_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic PULSE_OUT_PIN,
  input wire logic PULSE_OUT_OE,
  input wire logic ASLEEP,
  input wire logic [2:0] LEVEL
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  property p_rst; $fell(RESET) |-> !PULSE_OUT_PIN && ASLEEP && LEVEL == 3'h0; endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  property p_oe; !RESET |=> PULSE_OUT_OE; endproperty
  a_oe: assert property (p_oe) else $error("pulse pin not driven");
  property p_range; LEVEL <= 3'h5; endproperty
  a_range: assert property (p_range) else $error("level out of range");
  property p_step; $changed(LEVEL) |-> LEVEL == $past(LEVEL) + 3'h1 || LEVEL == 3'h0; endproperty
  a_step: assert property (p_step) else $error("level skipped");
  property p_wrap; $changed(LEVEL) && $past(LEVEL) == 3'h0 |-> LEVEL == 3'h1; endproperty
  a_wrap: assert property (p_wrap) else $error("wake not at lowest level");
  property p_off_low; (LEVEL == 3'h0) [*3] |-> !PULSE_OUT_PIN; endproperty
  a_off_low: assert property (p_off_low) else $error("pulse while off");
  property p_awake; (LEVEL != 3'h0) [*2] |-> !ASLEEP; endproperty
  a_awake: assert property (p_awake) else $error("asleep while lit");
  property p_high_max; $rose(PULSE_OUT_PIN) |-> ##[1:13] !PULSE_OUT_PIN; endproperty
  a_high_max: assert property (p_high_max) else $error("high time not below period");
endmodule

bind bld_dimmer bld_dimmer_chk i_bld_dimmer_chk (.CORE_CLK(CORE_CLK), .RESET(RESET),
  .PULSE_OUT_PIN(PULSE_OUT_PIN), .PULSE_OUT_OE(PULSE_OUT_OE), .ASLEEP(ASLEEP), .LEVEL(LEVEL));

// ---- testbench/bld_regulator.sv ----
// partner: regulator shutdown input, measures pulse high time and period
`timescale 1ns/1ps
module bld_regulator
(
  input wire logic clk,
  input wire logic shutdown_in,
  output logic [7:0] hi_len,
  output logic [7:0] per_len
);
  logic [7:0] cnt_q;
  logic last_q;
  // counts are in clock samples, so they compare directly with the tick constants
  always @(posedge clk)
  begin
    last_q <= shutdown_in;
    cnt_q <= (shutdown_in && !last_q) ? 8'h01 : cnt_q + 8'h01;
    if (shutdown_in && !last_q)
      per_len <= cnt_q;
    if (!shutdown_in && last_q)
      hi_len <= cnt_q;
  end
endmodule

// ---- testbench/bld_dimmer_test.sv ----
// testbench: stepped led dimmer scenarios
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module bld_dimmer_test;
  import bld_pkg::*;
  logic clk, rst, pwr, btn_n, gp1, gp2, pin, oe, asleep;
  logic [2:0] level;
  logic [7:0] hi_len, per_len;
  logic [7:0] hi_tab [5];
  int fails, n_tests, cyc;
  bld_dimmer #(.MAX_ON_CYC(2000), .DEBOUNCE_CYC(4)) i_bld_dimmer (.CORE_CLK(clk), .RESET(rst),
    .POWER_ON(pwr), .BUTTON_IN_PIN_N(btn_n), .GP_IN1(gp1), .GP_IN2(gp2), .PULSE_OUT_PIN(pin),
    .PULSE_OUT_OE(oe), .ASLEEP(asleep), .LEVEL(level));
  bld_regulator i_bld_regulator (.clk(clk), .shutdown_in(pin), .hi_len(hi_len), .per_len(per_len));
  // --------------------
  // clock and hang guard
  // --------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_of_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // long enough low for debounce, then several pwm periods to settle
  task automatic press();
    btn_n = 1'b0;
    tick(12);
    btn_n = 1'b1;
    tick(40);
  endtask
  // --------------------
  // scenarios
  // --------------------
  task automatic t_reset();
    pwr = 1'b1;
    tick(50);
    `CHK("asleep", 1'b1, asleep)
    `CHK("level", 3'h0, level)
    `CHK("pin", 1'b0, pin)
    `CHK("oe", 1'b1, oe)
  endtask
  task automatic t_steps();
    for (int k = 1; k <= 5; k++)
    begin
      press();
      `CHK("level", 3'(k), level)
      `CHK("high", hi_tab[k-1], hi_len)
      `CHK("period", BLD_PERIOD, per_len)
    end
    press();
    `CHK("level", 3'h0, level)
    `CHK("asleep", 1'b1, asleep)
    press();
    `CHK("level", 3'h1, level)
    `CHK("asleep", 1'b0, asleep)
  endtask
  // about 45 running cycles have passed already; the limit in this bench is 2000
  task automatic t_timeout();
    tick(1900);
    `CHK("awake", 1'b0, asleep)
    `CHK("lit", 3'h1, level)
    tick(200);
    `CHK("level", 3'h0, level)
    `CHK("asleep", 1'b1, asleep)
    `CHK("pin", 1'b0, pin)
  endtask
  task automatic t_wake();
    btn_n = 1'b0;
    tick(2);
    btn_n = 1'b1;
    tick(40);
    `CHK("level", 3'h0, level)
    gp1 = 1'b1;
    tick(40);
    gp2 = 1'b1;
    tick(40);
    `CHK("level", 3'h0, level)
    `CHK("asleep", 1'b1, asleep)
    press();
    `CHK("level", 3'h1, level)
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    hi_tab = '{BLD_LOW_ON, BLD_MED_ON, BLD_MEDHI_ON, BLD_HIGH_ON, BLD_FULL_ON};
    rst = 1'b1;
    pwr = 1'b0;
    btn_n = 1'b1;
    gp1 = 1'b0;
    gp2 = 1'b0;
    tick(12);
    rst = 1'b0;
    t_reset();
    t_steps();
    t_timeout();
    t_wake();
    end_of_test();
  end
endmodule
